// File: design/psag_pkg.sv
// Package: constants and types of the program space address generator
package psag_pkg;
  localparam int DATA_W = 16;
  localparam int PROG_W = 24;
  localparam int FILE_ADDR_W = 13;
  localparam int SHORT_LIT_W = 5;
  localparam int OFFSET_FIELD_W = 4;
  localparam int BRANCH_LIT_W = 16;
  localparam int INT_DIS_LIT_W = 14;
  localparam int PAGE_W = 8;
  localparam int PAGE_CFG_BIT = 7;
  localparam int VIS_EN_BIT = 2;
  localparam int EA_MSB = 15;
  localparam int PC_STEP = 2;
  // Register indices on the plain port
  localparam logic [3:0] OFF_TABLE_PAGE = 4'h0;
  localparam logic [3:0] OFF_VIS_PAGE = 4'h1;
  localparam logic [3:0] OFF_CORE_CONTROL = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;
  localparam logic [7:0] RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0] RST_VIS_PAGE = 8'h00;
  localparam logic [15:0] RST_CORE_CONTROL = 16'h0000;
  localparam logic [1:0] EXTRA_MOVE = 2'h1;
  localparam logic [1:0] EXTRA_OTHER = 2'h2;
  localparam logic [1:0] EXTRA_LOOP_FAST = 2'h0;
  typedef enum logic [2:0] {
    PSAG_DIRECT = 3'h0,
    PSAG_INDIRECT = 3'h1,
    PSAG_POST_MOD = 3'h3,
    PSAG_PRE_MOD = 3'h2,
    PSAG_INDEXED = 3'h6,
    PSAG_LIT_OFFSET = 3'h7,
    PSAG_FILE_REG = 3'h5
  } psag_mode_t;
  typedef enum logic [1:0] {
    PSAG_IDLE = 2'h0,
    PSAG_STALL1 = 2'h1,
    PSAG_STALL2 = 2'h3
  } psag_state_t;
endpackage : psag_pkg

// File: design/psag_top.sv
// Program space address generator: operand EA and program space mapping
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/10ps
// How it works
// - File register address is 13 bits, near 8192 bytes; move reaches all
// - Operand one register direct; operand two register, memory or literal
// - Post-modified: pointer is the address, then stepped by a constant
// - Pre-modified: pointer stepped by signed constant first, then used
// - Indexed: address is pointer plus base offset register
// - Literal offset: address is pointer plus instruction literal
// - Move modes may differ; source and destination share 4-bit offset
// - Branch target 16-bit signed literal; disable count 14-bit unsigned
// - Table address is table page above the 16-bit address
// - Table page bit 7 chooses user or configuration memory
// - Visibility read: page above low 15 bits, 23-bit user address
// - Visibility only when core control bit 2 is set
// - Address bit 15 dropped; program bit 15 from page bit 0
// - Word low table read returns program bits 15 to 0
// - Byte low table read picks upper byte when select is 1
// - Word high table read returns bits 23 to 16, upper byte zero
// - Byte high read of the phantom byte returns zero
// - Visibility reads cost an extra cycle for two fetches, except mid repeat loop
// - Visibility suspended while a table read or write runs
// - Outside repeat: moves add one cycle, others add two
// - In repeat: first, last, interrupt exit, re-entry add two; others none
// - Program counter steps by two per program word
module psag_top #(
  parameter int DATA_W = psag_pkg::DATA_W,
  parameter int PROG_W = psag_pkg::PROG_W
) (
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  input  wire logic [3:0]           REG_ADDR,
  input  wire logic [15:0]          REG_WDATA,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  output logic      [15:0]          REG_RDATA,
  input  wire logic                 OP_VALID,
  input  wire psag_pkg::psag_mode_t OP_MODE,
  input  wire logic                 OP_IS_MOVE,
  input  wire logic [15:0]          OP_POINTER,
  input  wire logic [15:0]          OP_BASE_OFFSET,
  input  wire logic [15:0]          OP_LITERAL,
  input  wire logic [12:0]          OP_FILE_ADDR,
  input  wire logic [15:0]          OP_STEP,
  output logic      [15:0]          EA,
  output logic      [15:0]          POINTER_NEXT,
  output logic                      POINTER_WE,
  input  wire logic                 TBL_VALID,
  input  wire logic                 TBL_HIGH,
  input  wire logic                 TBL_BYTE,
  input  wire logic                 TBL_WRITE,
  input  wire logic [15:0]          TBL_EA,
  output logic      [23:0]          PROG_ADDR,
  output logic                      PROG_CFG_SPACE,
  output logic                      PROG_RD,
  input  wire logic [23:0]          PROG_WORD,
  output logic      [15:0]          RD_DATA,
  output logic                      RD_DATA_VALID,
  output logic                      VIS_HIT,
  input  wire logic                 IN_REPEAT,
  input  wire logic                 REP_EDGE,
  output logic      [1:0]           EXTRA_CYCLES,
  output logic                      STALL,
  input  wire logic [15:0]          PC,
  output logic      [23:0]          PC_NEXT,
  input  wire logic [15:0]          BRANCH_LIT,
  input  wire logic [13:0]          INT_DIS_LIT,
  output logic      [23:0]          BRANCH_TARGET,
  output logic      [13:0]          INT_DIS_COUNT,
  input  wire logic [3:0]           OFFSET_FIELD,
  output logic      [3:0]           OFFSET_SEL
);
  logic [7:0]  table_page;
  logic [7:0]  visibility_page;
  logic [15:0] core_control;
  logic        program_visibility_enable;
  logic [15:0] next_ea;
  logic [15:0] next_pointer;
  logic        next_pointer_we;
  logic        vis_req;
  logic [23:0] next_prog_addr;
  logic [15:0] next_rd_data;
  logic        rd_table;
  logic        rd_high;
  logic        rd_byte;
  logic        rd_sel;
  logic [1:0]  next_extra;
  logic [1:0]  stall_cnt;
  psag_pkg::psag_state_t state;
  psag_pkg::psag_state_t next_state;

  default clocking chk_clk @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // Register writes
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      table_page <= psag_pkg::RST_TABLE_PAGE;
      visibility_page <= psag_pkg::RST_VIS_PAGE;
      core_control <= psag_pkg::RST_CORE_CONTROL;
    end else if (REG_WR) begin
      case (REG_ADDR)
        psag_pkg::OFF_TABLE_PAGE: table_page <= REG_WDATA[7:0];
        psag_pkg::OFF_VIS_PAGE: visibility_page <= REG_WDATA[7:0];
        psag_pkg::OFF_CORE_CONTROL: core_control <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped reads as zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
    end else if (REG_RD) begin
      case (REG_ADDR)
        psag_pkg::OFF_TABLE_PAGE: REG_RDATA <= {8'h00, table_page};
        psag_pkg::OFF_VIS_PAGE: REG_RDATA <= {8'h00, visibility_page};
        psag_pkg::OFF_CORE_CONTROL: REG_RDATA <= core_control;
        psag_pkg::OFF_STATUS: REG_RDATA <= {13'h0000, STALL, stall_cnt};
        default: REG_RDATA <= 16'h0000;
      endcase
    end else begin
      REG_RDATA <= 16'h0000;
    end
  end

  assign program_visibility_enable = core_control[psag_pkg::VIS_EN_BIT];

  // Effective address per mode
  always_comb begin
    next_ea = OP_POINTER;
    next_pointer = OP_POINTER;
    next_pointer_we = 1'b0;
    case (OP_MODE)
      psag_pkg::PSAG_FILE_REG:
        next_ea = OP_IS_MOVE ? OP_LITERAL : {3'h0, OP_FILE_ADDR};
      // Register direct passes the register itself
      psag_pkg::PSAG_DIRECT: next_ea = OP_POINTER;
      psag_pkg::PSAG_INDIRECT: next_ea = OP_POINTER;
      psag_pkg::PSAG_POST_MOD: begin
        next_ea = OP_POINTER;
        next_pointer = OP_POINTER + OP_STEP;
        next_pointer_we = 1'b1;
      end
      psag_pkg::PSAG_PRE_MOD: begin
        next_pointer = OP_POINTER + OP_STEP;
        next_ea = next_pointer;
        next_pointer_we = 1'b1;
      end
      psag_pkg::PSAG_INDEXED: next_ea = OP_POINTER + OP_BASE_OFFSET;
      psag_pkg::PSAG_LIT_OFFSET: next_ea = OP_POINTER + OP_LITERAL;
      default: next_ea = OP_POINTER;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      EA <= 16'h0000;
      POINTER_NEXT <= 16'h0000;
      POINTER_WE <= 1'b0;
      OFFSET_SEL <= 4'h0;
    end else begin
      EA <= next_ea;
      POINTER_NEXT <= next_pointer;
      POINTER_WE <= OP_VALID & next_pointer_we;
      OFFSET_SEL <= OFFSET_FIELD;
    end
  end

  assign vis_req = OP_VALID & program_visibility_enable &
                   next_ea[psag_pkg::EA_MSB] & ~TBL_VALID;

  always_comb begin
    next_prog_addr = {table_page, TBL_EA};
    // Visibility page above low 15 bits
    // Bit 15 comes from page bit 0
    if (vis_req) begin
      next_prog_addr = {1'b0, visibility_page, next_ea[14:0]};
    end
  end

  // The word answers a cycle after its address, so shape it by these
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_table <= 1'b0;
      rd_high <= 1'b0;
      rd_byte <= 1'b0;
      rd_sel <= 1'b0;
    end else begin
      rd_table <= TBL_VALID;
      rd_high <= TBL_HIGH;
      rd_byte <= TBL_BYTE;
      rd_sel <= TBL_EA[0];
    end
  end

  // Table read data shaping
  always_comb begin
    next_rd_data = PROG_WORD[15:0];
    if (!rd_table) begin
      // Visibility sees the low program word only
      next_rd_data = PROG_WORD[15:0];
    end else if (!rd_high && !rd_byte) begin
      next_rd_data = PROG_WORD[15:0];
    end else if (!rd_high) begin
      next_rd_data = {8'h00, rd_sel ? PROG_WORD[15:8] : PROG_WORD[7:0]};
    end else if (!rd_byte) begin
      // Word high with phantom byte zero
      next_rd_data = {8'h00, PROG_WORD[23:16]};
    end else begin
      next_rd_data = rd_sel ? 16'h0000 : {8'h00, PROG_WORD[23:16]};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PROG_ADDR <= 24'h000000;
      PROG_CFG_SPACE <= 1'b0;
      PROG_RD <= 1'b0;
      VIS_HIT <= 1'b0;
      RD_DATA <= 16'h0000;
      RD_DATA_VALID <= 1'b0;
    end else begin
      PROG_ADDR <= next_prog_addr;
      PROG_CFG_SPACE <= TBL_VALID & table_page[psag_pkg::PAGE_CFG_BIT];
      PROG_RD <= (TBL_VALID & ~TBL_WRITE) | vis_req;
      VIS_HIT <= vis_req;
      // Word of the previous cycle's fetch; held while nothing returns
      if (PROG_RD) begin
        RD_DATA <= next_rd_data;
      end
      RD_DATA_VALID <= PROG_RD;
    end
  end

  // Extra cycles for a visibility access
  always_comb begin
    next_extra = 2'h0;
    if (vis_req) begin
      if (IN_REPEAT) begin
        // Edge iterations cost two, others none
        next_extra = REP_EDGE ? psag_pkg::EXTRA_OTHER
                              : psag_pkg::EXTRA_LOOP_FAST;
      end else begin
        // At least one cycle for the second fetch
        next_extra = OP_IS_MOVE ? psag_pkg::EXTRA_MOVE
                                : psag_pkg::EXTRA_OTHER;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      psag_pkg::PSAG_IDLE:
        if (next_extra == 2'h2) next_state = psag_pkg::PSAG_STALL2;
        else if (next_extra == 2'h1) next_state = psag_pkg::PSAG_STALL1;
      psag_pkg::PSAG_STALL2: next_state = psag_pkg::PSAG_STALL1;
      psag_pkg::PSAG_STALL1: next_state = psag_pkg::PSAG_IDLE;
      default: next_state = psag_pkg::PSAG_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= psag_pkg::PSAG_IDLE;
      EXTRA_CYCLES <= 2'h0;
      stall_cnt <= 2'h0;
    end else begin
      state <= next_state;
      if (state == psag_pkg::PSAG_IDLE) begin
        EXTRA_CYCLES <= next_extra;
        stall_cnt <= next_extra;
      end else begin
        stall_cnt <= stall_cnt - 2'h1;
      end
    end
  end

  assign STALL = (state != psag_pkg::PSAG_IDLE);

  // Literal paths and program counter
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PC_NEXT <= 24'h000000;
      BRANCH_TARGET <= 24'h000000;
      INT_DIS_COUNT <= 14'h0000;
    end else begin
      PC_NEXT <= {8'h00, PC} + 24'(psag_pkg::PC_STEP);
      BRANCH_TARGET <= {8'h00, PC} + {{8{BRANCH_LIT[15]}}, BRANCH_LIT};
      INT_DIS_COUNT <= INT_DIS_LIT;
    end
  end

  chk_vis_addr_form: assert property (
    vis_req |=> PROG_ADDR[15] == $past(visibility_page[0]) && !PROG_ADDR[23])
    else $error("visibility address bit 15 wrong");
  chk_vis_enable_gate: assert property (
    !program_visibility_enable |=> !VIS_HIT)
    else $error("visibility without enable");
  chk_table_suspends: assert property (
    TBL_VALID |=> !VIS_HIT)
    else $error("visibility during table access");
  chk_table_addr: assert property (
    TBL_VALID |=> PROG_ADDR == {$past(table_page), $past(TBL_EA)})
    else $error("table address wrong");
  chk_cfg_select: assert property (
    TBL_VALID |=> PROG_CFG_SPACE == $past(table_page[psag_pkg::PAGE_CFG_BIT]))
    else $error("configuration select wrong");
  chk_phantom_zero: assert property (
    TBL_VALID && TBL_HIGH && !TBL_WRITE |=> ##1 RD_DATA[15:8] == 8'h00)
    else $error("phantom byte not zero");
  chk_word_low: assert property (
    TBL_VALID && !TBL_WRITE && !TBL_HIGH && !TBL_BYTE
    |=> ##1 RD_DATA == $past(PROG_WORD[15:0]))
    else $error("word low read wrong");
  chk_move_stall_one: assert property (
    !STALL && vis_req && !IN_REPEAT && OP_IS_MOVE |=> STALL ##1 !STALL)
    else $error("move stall not one cycle");
  chk_other_stall_two: assert property (
    !STALL && vis_req && !IN_REPEAT && !OP_IS_MOVE |=> STALL[*2] ##1 !STALL)
    else $error("other stall not two cycles");
  chk_repeat_fast: assert property (
    !STALL && vis_req && IN_REPEAT && !REP_EDGE |=> !STALL)
    else $error("mid loop stall");
  chk_pc_step: assert property (
    1'b1 |=> PC_NEXT == {8'h00, $past(PC)} + 24'h000002)
    else $error("pc step wrong");
  chk_post_mod_ea: assert property (
    OP_MODE == psag_pkg::PSAG_POST_MOD |=> EA == $past(OP_POINTER))
    else $error("post modify address wrong");
  chk_pre_mod_ea: assert property (
    OP_MODE == psag_pkg::PSAG_PRE_MOD |=>
    EA == $past(OP_POINTER) + $past(OP_STEP))
    else $error("pre modify address wrong");
  chk_indexed_ea: assert property (
    OP_MODE == psag_pkg::PSAG_INDEXED |=>
    EA == $past(OP_POINTER) + $past(OP_BASE_OFFSET))
    else $error("indexed address wrong");
  chk_lit_offset_ea: assert property (
    OP_MODE == psag_pkg::PSAG_LIT_OFFSET |=>
    EA == $past(OP_POINTER) + $past(OP_LITERAL))
    else $error("literal offset address wrong");
  chk_file_near: assert property (
    OP_MODE == psag_pkg::PSAG_FILE_REG && !OP_IS_MOVE |=>
    EA == {3'h0, $past(OP_FILE_ADDR)})
    else $error("file register address wrong");

  cov_vis_read: cover property (@(posedge CLK) disable iff (!RST_N) VIS_HIT);
  cov_table_cfg: cover property (@(posedge CLK) disable iff (!RST_N)
    PROG_CFG_SPACE);
  cov_repeat_edge: cover property (@(posedge CLK) disable iff (!RST_N)
    vis_req && IN_REPEAT && REP_EDGE);
  cov_move_stall: cover property (@(posedge CLK) disable iff (!RST_N)
    vis_req && OP_IS_MOVE && !IN_REPEAT);
endmodule : psag_top

// File: tb/psag_flash_model.sv
// Program flash model answering with an address-keyed word
`timescale 1ns/10ps
module psag_flash_model (
  input  wire logic        clk,
  input  wire logic [23:0] prog_addr,
  input  wire logic        prog_rd,
  output logic      [23:0] prog_word
);
  logic [23:0] last = 24'h000000;
  // Every address gives a distinct word, so a wrong address reads wrong
  function automatic logic [23:0] word_at(logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'hC3A5};
  endfunction : word_at
  always_ff @(posedge clk) begin
    last <= prog_word;
  end
  // Unselected array shows a changing pattern, never the last word
  always_comb begin
    prog_word = prog_rd ? word_at(prog_addr) : ~last;
  end
endmodule : psag_flash_model

// File: tb/psag_top_bench.sv
// Self-checking bench of the program space address generator
`timescale 1ns/10ps
module psag_top_bench;
  logic CLK, RST_N, REG_WR, REG_RD, OP_VALID, OP_IS_MOVE, TBL_VALID;
  logic TBL_HIGH, TBL_BYTE, TBL_WRITE, PROG_CFG_SPACE, PROG_RD;
  logic RD_DATA_VALID, VIS_HIT, POINTER_WE, STALL, IN_REPEAT, REP_EDGE;
  logic [3:0]  REG_ADDR, OFFSET_FIELD, OFFSET_SEL;
  logic [1:0]  EXTRA_CYCLES;
  logic [12:0] OP_FILE_ADDR;
  logic [13:0] INT_DIS_LIT, INT_DIS_COUNT;
  logic [15:0] REG_WDATA, REG_RDATA, OP_POINTER, OP_BASE_OFFSET, OP_LITERAL;
  logic [15:0] OP_STEP, EA, POINTER_NEXT, TBL_EA, RD_DATA, PC, BRANCH_LIT;
  logic [23:0] PROG_ADDR, PROG_WORD, PC_NEXT, BRANCH_TARGET;
  psag_pkg::psag_mode_t OP_MODE;
  int          mismatches, n_tests;

  psag_top i_psag_top (.CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .OP_VALID, .OP_MODE, .OP_IS_MOVE, .OP_POINTER,
    .OP_BASE_OFFSET, .OP_LITERAL, .OP_FILE_ADDR, .OP_STEP, .EA,
    .POINTER_NEXT, .POINTER_WE, .TBL_VALID, .TBL_HIGH, .TBL_BYTE,
    .TBL_WRITE, .TBL_EA, .PROG_ADDR, .PROG_CFG_SPACE, .PROG_RD, .PROG_WORD,
    .RD_DATA, .RD_DATA_VALID, .VIS_HIT, .IN_REPEAT, .REP_EDGE,
    .EXTRA_CYCLES, .STALL, .PC, .PC_NEXT, .BRANCH_LIT, .INT_DIS_LIT,
    .BRANCH_TARGET, .INT_DIS_COUNT, .OFFSET_FIELD, .OFFSET_SEL);
  psag_flash_model i_psag_flash_model (.clk(CLK), .prog_addr(PROG_ADDR),
    .prog_rd(PROG_RD), .prog_word(PROG_WORD));

  always #50 CLK = ~CLK;

  task automatic chk(logic [23:0] s, logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(logic [3:0] a, logic [15:0] e);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    chk(REG_RDATA, e);
  endtask : rd

  // One operand request; returns just after the edge that takes it
  task automatic op(psag_pkg::psag_mode_t m, logic [15:0] p,
                    logic [15:0] x, logic mv);
    @(posedge CLK);
    OP_VALID <= 1'b1;
    OP_MODE <= m;
    OP_POINTER <= p;
    OP_BASE_OFFSET <= x;
    OP_LITERAL <= x;
    OP_STEP <= x;
    OP_FILE_ADDR <= x[12:0];
    OP_IS_MOVE <= mv;
    @(posedge CLK);
    OP_VALID <= 1'b0;
    #1;
  endtask : op

  task automatic tbl(logic h, logic b, logic [15:0] ea, logic [7:0] tp);
    logic [23:0] w;
    logic [15:0] e;
    w = {tp ^ ea[7:0], ea ^ 16'hC3A5};
    if (h) e = (b && ea[0]) ? 16'h0000 : {8'h00, w[23:16]};
    else if (!b) e = w[15:0];
    else e = {8'h00, ea[0] ? w[15:8] : w[7:0]};
    @(posedge CLK);
    TBL_VALID <= 1'b1;
    TBL_HIGH <= h;
    TBL_BYTE <= b;
    TBL_EA <= ea;
    @(posedge CLK);
    TBL_VALID <= 1'b0;
    #1;
    chk(PROG_ADDR, {tp, ea});
    chk(24'(PROG_CFG_SPACE), 24'(tp[7]));
    chk(24'(PROG_RD), 24'h000001);
    for (int n = 0; n < 4 && RD_DATA_VALID !== 1'b1; n++) @(posedge CLK) #1;
    chk(24'(RD_DATA_VALID), 24'h000001);
    chk(24'(RD_DATA), 24'(e));
  endtask : tbl

  // Flags f: move, in repeat, repeat edge, table busy, expected hit
  task automatic vis(logic [15:0] p, logic [4:0] f, logic [1:0] x);
    int n;
    IN_REPEAT <= f[3];
    REP_EDGE <= f[2];
    TBL_VALID <= f[1];
    TBL_WRITE <= f[1];
    op(psag_pkg::PSAG_INDIRECT, p, 16'h0000, f[4]);
    TBL_VALID <= 1'b0;
    chk(24'(VIS_HIT), 24'(f[0]));
    chk(24'(PROG_RD), 24'(f[0]));
    chk(24'(EXTRA_CYCLES), 24'(x));
    if (f[0]) chk(PROG_ADDR, {1'b0, 8'h35, p[14:0]});
    n = 0;
    while (STALL === 1'b1 && n < 6) begin
      n++;
      @(posedge CLK) #1;
    end
    chk(24'(n), 24'(x));
    // Page 35 puts a one into program address bit 15
    if (f[0] && n == 0) @(posedge CLK) #1;
    if (f[0]) chk(24'(RD_DATA), 24'({1'b1, p[14:0]} ^ 16'hC3A5));
  endtask : vis

  initial begin
    #(3000 * 100);
    mismatches++;
    finish_test();
  end

  initial begin
    {CLK, RST_N, REG_WR, REG_RD, OP_VALID, OP_IS_MOVE, TBL_VALID} = '0;
    {TBL_HIGH, TBL_BYTE, TBL_WRITE, IN_REPEAT, REP_EDGE, REG_ADDR} = '0;
    {OFFSET_FIELD, OP_FILE_ADDR, INT_DIS_LIT, REG_WDATA, OP_POINTER} = '0;
    {OP_BASE_OFFSET, OP_LITERAL, OP_STEP, TBL_EA, PC, BRANCH_LIT} = '0;
    OP_MODE = psag_pkg::PSAG_DIRECT;
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    // Reset values, field width, unmapped write
    rd(psag_pkg::OFF_TABLE_PAGE, 16'h0000);
    rd(psag_pkg::OFF_VIS_PAGE, 16'h0000);
    rd(psag_pkg::OFF_CORE_CONTROL, 16'h0000);
    rd(psag_pkg::OFF_STATUS, 16'h0000);
    wr(psag_pkg::OFF_TABLE_PAGE, 16'hFFFF);
    wr(4'hF, 16'h1234);
    rd(psag_pkg::OFF_TABLE_PAGE, 16'h00FF);
    wr(psag_pkg::OFF_VIS_PAGE, 16'h0035);
    rd(psag_pkg::OFF_VIS_PAGE, 16'h0035);
    op(psag_pkg::PSAG_POST_MOD, 16'h1000, 16'h0002, 1'b0);
    chk(24'(EA), 24'h001000);
    chk(24'(POINTER_NEXT), 24'h001002);
    chk(24'(POINTER_WE), 24'h000001);
    op(psag_pkg::PSAG_PRE_MOD, 16'h1000, 16'hFFFE, 1'b0);
    chk(24'(EA), 24'h000FFE);
    chk(24'(POINTER_NEXT), 24'h000FFE);
    op(psag_pkg::PSAG_INDEXED, 16'h1000, 16'h0234, 1'b1);
    chk(24'(EA), 24'h001234);
    chk(24'(POINTER_WE), 24'h000000);
    op(psag_pkg::PSAG_LIT_OFFSET, 16'h1000, 16'h0010, 1'b0);
    chk(24'(EA), 24'h001010);
    op(psag_pkg::PSAG_DIRECT, 16'h2468, 16'h0000, 1'b0);
    chk(24'(EA), 24'h002468);
    op(psag_pkg::PSAG_FILE_REG, 16'h0000, 16'hFFFF, 1'b0);
    chk(24'(EA), 24'h001FFF);
    op(psag_pkg::PSAG_FILE_REG, 16'h0000, 16'h7ABC, 1'b1);
    chk(24'(EA), 24'h007ABC);
    @(posedge CLK);
    PC <= 16'h0100;
    BRANCH_LIT <= 16'hFFF0;
    INT_DIS_LIT <= 14'h3FFF;
    OFFSET_FIELD <= 4'hA;
    @(posedge CLK) #1;
    chk(PC_NEXT, 24'h000102);
    chk(BRANCH_TARGET, 24'h0000F0);
    chk(24'(INT_DIS_COUNT), 24'h003FFF);
    chk(24'(OFFSET_SEL), 24'h00000A);
    wr(psag_pkg::OFF_TABLE_PAGE, 16'h0081);
    for (int i = 0; i < 6; i++)
      tbl(i > 2, i % 3 != 0, 16'h1234 + 16'(i % 3 == 2), 8'h81);
    wr(psag_pkg::OFF_TABLE_PAGE, 16'h0002);
    tbl(1'b0, 1'b0, 16'h4566, 8'h02);
    wr(psag_pkg::OFF_CORE_CONTROL, 16'h0004);
    vis(16'h8010, 5'b00001, 2'h2);
    vis(16'h8010, 5'b10001, 2'h1);
    vis(16'h8010, 5'b01101, 2'h2);
    vis(16'h8010, 5'b01001, 2'h0);
    vis(16'h0010, 5'b00000, 2'h0);
    vis(16'h8010, 5'b00010, 2'h0);
    wr(psag_pkg::OFF_CORE_CONTROL, 16'h0000);
    vis(16'h8010, 5'b00000, 2'h0);
    finish_test();
  end
endmodule : psag_top_bench
